// ==== hw/adc_link_pkg.sv ====
// shared constants and types for the sample output link and its capture controller
package adc_link_pkg;
  localparam int WORD_W         = 16;
  localparam int ANALOG_W       = 18;
  localparam int LATENCY        = 7;
  localparam int MCLK_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;

  localparam logic signed [ANALOG_W+1:0] FS_MAX = 20'sh07fff;
  localparam logic signed [ANALOG_W+1:0] FS_MIN = 20'shf8000;
  localparam logic [WORD_W-1:0] CLAMP_HI = 16'h7fff;
  localparam logic [WORD_W-1:0] CLAMP_LO = 16'h8000;

  // strap levels in order: ground, one third, two thirds, full supply
  typedef enum logic [1:0] {
    MODE_OFFSET_PLAIN,
    MODE_OFFSET_STAB,
    MODE_TWOS_STAB,
    MODE_TWOS_PLAIN
  } mode_strap_t;

  typedef enum logic [1:0] {
    SRC_STROBE_P,
    SRC_STROBE_N,
    SRC_SAMPLE_CLOCK,
    SRC_SPARE
  } capture_src_t;

  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_MASK   = 4'h8;
  localparam logic [ADDR_W-1:0] REG_DATA   = 4'hc;

  localparam int CTRL_W           = 6;
  localparam int CTRL_CAPTURE_EN  = 0;
  localparam int CTRL_DESCRAMBLE  = 1;
  localparam int CTRL_SRC_LSB     = 2;
  localparam int CTRL_OUT_DISABLE = 4;
  localparam int CTRL_POWER_DOWN  = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

  localparam int ST_W       = 3;
  localparam int ST_SAMPLE  = 0;
  localparam int ST_RANGE   = 1;
  localparam int ST_OVERRUN = 2;
  localparam logic [ST_W-1:0] STATUS_RESET = 3'h0;
  localparam logic [ST_W-1:0] MASK_RESET   = 3'h0;
endpackage

// ==== hw/adc_link_if.sv ====
// pin-level carrier between the converter output end and the capture end
`timescale 1ns/1ps
interface adc_link_if;
  // sample clock pair, made by the bench
  logic        sample_clock_pos;
  logic        sample_clock_neg;
  // device drive side
  logic [15:0] word_drv;
  logic        flag_drv;
  logic        strobe_p_drv;
  logic        strobe_n_drv;
  logic        out_oe_n;
  // receiver control pins
  logic        output_drive_disable;
  logic        power_down_pin;
  // resolved wires; a released bus is modelled as pulled low
  logic [15:0] sample_word_bits;
  logic        range_exceed_flag;
  logic        valid_strobe_p;
  logic        valid_strobe_n;

  assign sample_word_bits  = out_oe_n ? 16'h0000 : word_drv;
  assign range_exceed_flag = out_oe_n ? 1'b0 : flag_drv;
  assign valid_strobe_p    = out_oe_n ? 1'b0 : strobe_p_drv;
  assign valid_strobe_n    = out_oe_n ? 1'b0 : strobe_n_drv;

  modport device (
    input  sample_clock_pos,
    input  sample_clock_neg,
    input  output_drive_disable,
    input  power_down_pin,
    output word_drv,
    output flag_drv,
    output strobe_p_drv,
    output strobe_n_drv,
    output out_oe_n
  );

  modport receiver (
    input  sample_clock_pos,
    input  sample_clock_neg,
    input  sample_word_bits,
    input  range_exceed_flag,
    input  valid_strobe_p,
    input  valid_strobe_n,
    output output_drive_disable,
    output power_down_pin
  );
endinterface

// ==== hw/adc_output_end.sv ====
// converter digital output end: quantiser model, latency pipeline, strobes and drivers
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module adc_output_end #(
  parameter int LATENCY = adc_link_pkg::LATENCY
) (
  // clock and reset
  input  wire logic                                mclk,
  input  wire logic                                rst_n,
  // link pins
  adc_link_if.device                               link,
  // analog input, already in lsb units at unity gain
  input  wire logic signed [adc_link_pkg::ANALOG_W-1:0] analog_level,
  // board straps
  input  wire logic [1:0]                          output_format_strap,
  input  wire logic                                noise_inject_enable,
  input  wire logic                                output_scramble_select,
  input  wire logic                                front_gain_select,
  // state seen by the board
  output logic                                     dither_active,
  output logic                                     stabilizer_active,
  output logic                                     twos_complement_active,
  output logic                                     gain_high_active,
  output logic                                     converting
);
  localparam int W = adc_link_pkg::WORD_W;

  if (LATENCY < 1) begin : g_bad_latency
    $error("latency must be at least one sample clock");
  end

  typedef logic [W:0] entry_t;

  function automatic logic mode_twos(input logic [1:0] code);
    adc_link_pkg::mode_strap_t m;
    m = adc_link_pkg::mode_strap_t'(code);
    return (m == adc_link_pkg::MODE_TWOS_STAB) || (m == adc_link_pkg::MODE_TWOS_PLAIN);
  endfunction

  function automatic logic mode_stab(input logic [1:0] code);
    adc_link_pkg::mode_strap_t m;
    m = adc_link_pkg::mode_strap_t'(code);
    return (m == adc_link_pkg::MODE_OFFSET_STAB) || (m == adc_link_pkg::MODE_TWOS_STAB);
  endfunction

  // one conversion: gain, clamp, format, scramble; flag in the top bit
  function automatic entry_t convert(
    input logic signed [adc_link_pkg::ANALOG_W-1:0] level,
    input logic                                     gain_high,
    input logic [1:0]                               mode,
    input logic                                     scramble
  );
    logic signed [adc_link_pkg::ANALOG_W+1:0] scaled;
    logic signed [adc_link_pkg::ANALOG_W+1:0] half;
    logic                                     over;
    logic [W-1:0]                             word;
    scaled = (adc_link_pkg::ANALOG_W+2)'(level);
    half   = scaled >>> 1;
    if (gain_high) begin
      scaled = scaled + half;
    end
    over = (scaled > adc_link_pkg::FS_MAX) || (scaled < adc_link_pkg::FS_MIN);
    if (!over) begin
      word = scaled[W-1:0];
    end else if (scaled < 0) begin
      word = adc_link_pkg::CLAMP_LO;
    end else begin
      word = adc_link_pkg::CLAMP_HI;
    end
    if (!mode_twos(mode)) begin
      word[W-1] = ~word[W-1];
    end
    if (scramble) begin
      word[W-1:1] = word[W-1:1] ^ {(W-1){word[0]}};
    end
    return {over, word};
  endfunction

  // synchronisers: stage one feeds stage two only
  logic [1:0] pos_meta;
  logic [1:0] neg_meta;
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  logic       pos_s;
  logic       neg_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pos_meta <= 2'h0;
      neg_meta <= 2'h0;
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
    end else begin
      pos_meta <= {pos_meta[0], link.sample_clock_pos};
      neg_meta <= {neg_meta[0], link.sample_clock_neg};
      pin_meta <= {output_format_strap, noise_inject_enable, output_scramble_select,
                   front_gain_select, link.power_down_pin, link.output_drive_disable};
      pin_sync <= pin_meta;
    end
  end

  assign pos_s = pos_meta[1];
  assign neg_s = neg_meta[1];

  logic [1:0] mode_s;
  logic       noise_inject_enable_s;
  logic       scr_s;
  logic       gain_s;
  logic       pd_s;
  logic       oed_s;
  logic       enc_high;

  assign mode_s   = pin_sync[6:5];
  assign noise_inject_enable_s   = pin_sync[4];
  assign scr_s    = pin_sync[3];
  assign gain_s   = pin_sync[2];
  assign pd_s     = pin_sync[1];
  assign oed_s    = pin_sync[0];
  // differential compare of the clock pair
  assign enc_high = pos_s & ~neg_s;

  // main state
  entry_t     pipe [LATENCY];
  entry_t     next_pipe [LATENCY];
  logic       enc_prev;
  logic       next_enc_prev;
  logic [W-1:0] out_word;
  logic [W-1:0] next_out_word;
  logic       out_flag;
  logic       next_out_flag;
  logic       strobe_p;
  logic       next_strobe_p;
  logic       strobe_n;
  logic       next_strobe_n;
  logic       oe_n;
  logic       next_oe_n;
  logic [4:0] state_pins;
  logic [4:0] next_state_pins;
  logic       enc_rise;
  logic       enc_fall;

  assign enc_rise = enc_high & ~enc_prev;
  assign enc_fall = ~enc_high & enc_prev;

  always_comb begin
    for (int i = 0; i < LATENCY; i++) begin
      next_pipe[i] = pipe[i];
    end
    next_enc_prev = enc_high;
    next_out_word = out_word;
    next_out_flag = out_flag;
    next_strobe_p = strobe_p;
    next_strobe_n = strobe_n;
    // straps are sampled per conversion, so a change never tears a word in flight
    if (enc_rise && !pd_s) begin
      next_pipe[0] = convert(analog_level, gain_s, mode_s, scr_s);
      for (int i = 1; i < LATENCY; i++) begin
        next_pipe[i] = pipe[i-1];
      end
      next_out_word = pipe[LATENCY-1][W-1:0];
      next_out_flag = pipe[LATENCY-1][W];
      next_strobe_p = 1'b0;
      next_strobe_n = 1'b1;
    end
    // strobe edge lands mid period, half a cycle after the word settles
    if (enc_fall && !pd_s) begin
      next_strobe_p = 1'b1;
      next_strobe_n = 1'b0;
    end
    next_oe_n = pd_s | oed_s;
    next_state_pins = {noise_inject_enable_s, mode_stab(mode_s), mode_twos(mode_s), gain_s, ~pd_s};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe[i] <= '0;
      end
      enc_prev   <= 1'b0;
      out_word   <= 16'h0000;
      out_flag   <= 1'b0;
      strobe_p   <= 1'b0;
      strobe_n   <= 1'b1;
      oe_n       <= 1'b1;
      state_pins <= 5'h00;
    end else begin
      pipe       <= next_pipe;
      enc_prev   <= next_enc_prev;
      out_word   <= next_out_word;
      out_flag   <= next_out_flag;
      strobe_p   <= next_strobe_p;
      strobe_n   <= next_strobe_n;
      oe_n       <= next_oe_n;
      state_pins <= next_state_pins;
    end
  end

  assign link.word_drv      = out_word;
  assign link.flag_drv      = out_flag;
  assign link.strobe_p_drv  = strobe_p;
  assign link.strobe_n_drv  = strobe_n;
  assign link.out_oe_n      = oe_n;

  assign dither_active          = state_pins[4];
  assign stabilizer_active      = state_pins[3];
  assign twos_complement_active = state_pins[2];
  assign gain_high_active       = state_pins[1];
  assign converting             = state_pins[0];
endmodule

// ==== hw/adc_capture_end.sv ====
// capture controller: latches sample words off the link, avalon slave with interrupt
`timescale 1ns/1ps
module adc_capture_end (
  // clock and reset
  input  wire logic                             mclk,
  input  wire logic                             rst_n,
  // link pins
  adc_link_if.receiver                          link,
  // avalon-mm slave
  input  wire logic [adc_link_pkg::ADDR_W-1:0]  address,
  input  wire logic                             read,
  input  wire logic                             write,
  input  wire logic [31:0]                      writedata,
  input  wire logic [3:0]                       byteenable,
  output logic [31:0]                           readdata,
  output logic                                  waitrequest,
  output logic                                  irq,
  // captured stream
  output logic [adc_link_pkg::WORD_W-1:0]       sample_word_out,
  output logic                                  sample_flag_out,
  output logic                                  sample_strobe
);
  localparam int W = adc_link_pkg::WORD_W;

  // every link pin passes two flops; stage one is read only by stage two
  logic [W+4:0] meta;
  logic [W+4:0] sync;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= {link.sample_word_bits, link.range_exceed_flag, link.valid_strobe_p,
               link.valid_strobe_n, link.sample_clock_pos, link.sample_clock_neg};
      sync <= meta;
    end
  end

  logic [2:0]                       prev;
  logic [2:0]                       next_prev;
  logic [adc_link_pkg::CTRL_W-1:0]  ctrl;
  logic [adc_link_pkg::CTRL_W-1:0]  next_ctrl;
  logic [adc_link_pkg::ST_W-1:0]    status;
  logic [adc_link_pkg::ST_W-1:0]    next_status;
  logic [adc_link_pkg::ST_W-1:0]    mask;
  logic [adc_link_pkg::ST_W-1:0]    next_mask;
  logic [W-1:0]                     word;
  logic [W-1:0]                     next_word;
  logic                             flag;
  logic                             next_flag;
  logic                             strobe;
  logic                             next_strobe;
  logic [31:0]                      next_readdata;
  logic                             next_waitrequest;
  logic                             next_irq;
  logic                             take;
  logic                             live;
  logic [adc_link_pkg::ST_W-1:0]    set_bits;
  logic [W-1:0]                     raw;
  logic                             enc;
  adc_link_pkg::capture_src_t       src;

  assign raw = sync[W+4:5];
  // clock pair compared only after both pins are synchronised
  assign enc = sync[1] & ~sync[0];
  assign src = adc_link_pkg::capture_src_t'(ctrl[adc_link_pkg::CTRL_SRC_LSB +: 2]);
  // released or powered-down outputs carry nothing worth latching
  assign live = ctrl[adc_link_pkg::CTRL_CAPTURE_EN] & ~ctrl[adc_link_pkg::CTRL_OUT_DISABLE]
              & ~ctrl[adc_link_pkg::CTRL_POWER_DOWN];

  always_comb begin
    next_prev = {sync[3], sync[2], enc};
    case (src)
      adc_link_pkg::SRC_STROBE_N:     take = prev[1] & ~sync[2];
      adc_link_pkg::SRC_SAMPLE_CLOCK: take = ~prev[0] & enc;
      default:                        take = ~prev[2] & sync[3];
    endcase
    take = take & live;
    next_word   = word;
    next_flag   = flag;
    next_strobe = take;
    if (take) begin
      next_word = raw;
      if (ctrl[adc_link_pkg::CTRL_DESCRAMBLE]) begin
        next_word[W-1:1] = raw[W-1:1] ^ {(W-1){raw[0]}};
      end
      next_flag = sync[4];
    end
    set_bits = '0;
    set_bits[adc_link_pkg::ST_SAMPLE]  = take;
    set_bits[adc_link_pkg::ST_RANGE]   = take & sync[4];
    set_bits[adc_link_pkg::ST_OVERRUN] = take & status[adc_link_pkg::ST_SAMPLE];
    next_ctrl   = ctrl;
    next_mask   = mask;
    next_status = status;
    // access completes on the edge where waitrequest is low
    if (write && !waitrequest && byteenable[0]) begin
      case (address)
        adc_link_pkg::REG_CTRL:   next_ctrl   = writedata[adc_link_pkg::CTRL_W-1:0];
        adc_link_pkg::REG_MASK:   next_mask   = writedata[adc_link_pkg::ST_W-1:0];
        adc_link_pkg::REG_STATUS: next_status = status & ~writedata[adc_link_pkg::ST_W-1:0];
        default:                  next_status = status;
      endcase
    end
    // a new event beats a clear in the same cycle
    next_status = next_status | set_bits;
    next_irq = |(next_status & next_mask);
    next_waitrequest = !((read || write) && waitrequest);
    next_readdata = readdata;
    if (read && waitrequest) begin
      case (address)
        adc_link_pkg::REG_CTRL:   next_readdata = {26'h0, ctrl};
        adc_link_pkg::REG_STATUS: next_readdata = {29'h0, status};
        adc_link_pkg::REG_MASK:   next_readdata = {29'h0, mask};
        adc_link_pkg::REG_DATA:   next_readdata = {15'h0, flag, word};
        default:                  next_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev        <= 3'h0;
      ctrl        <= adc_link_pkg::CTRL_RESET;
      status      <= adc_link_pkg::STATUS_RESET;
      mask        <= adc_link_pkg::MASK_RESET;
      word        <= 16'h0000;
      flag        <= 1'b0;
      strobe      <= 1'b0;
      readdata    <= 32'h0;
      waitrequest <= 1'b1;
      irq         <= 1'b0;
    end else begin
      prev        <= next_prev;
      ctrl        <= next_ctrl;
      status      <= next_status;
      mask        <= next_mask;
      word        <= next_word;
      flag        <= next_flag;
      strobe      <= next_strobe;
      readdata    <= next_readdata;
      waitrequest <= next_waitrequest;
      irq         <= next_irq;
    end
  end

  assign sample_word_out           = word;
  assign sample_flag_out           = flag;
  assign sample_strobe             = strobe;
  assign link.output_drive_disable = ctrl[adc_link_pkg::CTRL_OUT_DISABLE];
  assign link.power_down_pin       = ctrl[adc_link_pkg::CTRL_POWER_DOWN];
endmodule

// ==== tb/adc_link_props.sv ====
// concurrent checks on the sample output link between the two ends
`timescale 1ns/1ps
module adc_link_props (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // link pins
  input wire logic        sample_clock_pos,
  input wire logic [15:0] word_drv,
  input wire logic        flag_drv,
  input wire logic        strobe_p_drv,
  input wire logic        strobe_n_drv,
  input wire logic        out_oe_n,
  input wire logic        output_drive_disable,
  input wire logic        power_down_pin
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // pins pass a synchroniser, so each reaction gets a few mclk of slack
  sequence s_rise_ready;
    (!power_down_pin) [*6] ##0 ($rose(sample_clock_pos) && !strobe_n_drv);
  endsequence
  sequence s_fall_ready;
    (!power_down_pin) [*6] ##0 ($fell(sample_clock_pos) && !strobe_p_drv);
  endsequence
  sequence s_word_held;
    ($stable(word_drv) && $stable(flag_drv)) [*3];
  endsequence

  chk_strobe_pair: assert property (strobe_p_drv == !strobe_n_drv)
    else $error("valid strobes not complementary");
  chk_sample_launch: assert property (s_rise_ready |-> ##[2:5] $rose(strobe_n_drv))
    else $error("no new word after rising sample clock");
  chk_valid_edge: assert property (s_fall_ready |-> ##[2:5] $rose(strobe_p_drv))
    else $error("positive strobe did not rise after falling sample clock");
  chk_load_phase: assert property (($changed(word_drv) || $changed(flag_drv)) |-> strobe_n_drv)
    else $error("word or flag changed outside the load phase");
  chk_word_hold: assert property ($rose(strobe_p_drv) |=> s_word_held)
    else $error("word moved after the latch edge");
  chk_strobe_rate: assert property ($rose(strobe_n_drv) |=> (!$rose(strobe_n_drv)) [*6])
    else $error("strobe toggled faster than the sample rate");
  chk_drive_off: assert property (output_drive_disable [*4] |-> out_oe_n)
    else $error("outputs driven while disabled");
  chk_drive_on: assert property ((!output_drive_disable && !power_down_pin) [*5] |-> !out_oe_n)
    else $error("outputs released while enabled");
  chk_power_freeze: assert property (power_down_pin [*5] |->
    out_oe_n && $stable(word_drv) && $stable(strobe_n_drv))
    else $error("link active while powered down");
endmodule

// ==== tb/adc_sample_output_interface_test.sv ====
// self-checking bench: output end and capture end joined by the link
`timescale 1ns/1ps
module adc_sample_output_interface_test;
  logic                                   mclk;
  logic                                   rst_n;
  logic [adc_link_pkg::ADDR_W-1:0]        address;
  logic                                   read;
  logic                                   write;
  logic [31:0]                            writedata;
  logic [3:0]                             byteenable;
  logic [31:0]                            readdata;
  logic                                   waitrequest;
  logic                                   irq;
  logic [adc_link_pkg::WORD_W-1:0]        sample_word_out;
  logic                                   sample_flag_out;
  logic                                   sample_strobe;
  logic signed [adc_link_pkg::ANALOG_W-1:0] analog_level;
  logic [1:0]                             output_format_strap;
  logic                                   noise_inject_enable;
  logic                                   output_scramble_select;
  logic                                   front_gain_select;
  logic                                   dither_active;
  logic                                   stabilizer_active;
  logic                                   twos_complement_active;
  logic                                   gain_high_active;
  logic                                   converting;
  logic [31:0]                            rdata;
  int                                     mismatches = 0;
  int                                     n_tests = 0;

  adc_link_if link ();
  adc_output_end adc_output_end_inst (.mclk(mclk), .rst_n(rst_n), .link(link),
    .analog_level(analog_level), .output_format_strap(output_format_strap),
    .noise_inject_enable(noise_inject_enable), .output_scramble_select(output_scramble_select),
    .front_gain_select(front_gain_select), .dither_active(dither_active),
    .stabilizer_active(stabilizer_active), .twos_complement_active(twos_complement_active),
    .gain_high_active(gain_high_active), .converting(converting));
  adc_capture_end adc_capture_end_inst (.mclk(mclk), .rst_n(rst_n), .link(link),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .sample_word_out(sample_word_out), .sample_flag_out(sample_flag_out),
    .sample_strobe(sample_strobe));
  adc_link_props adc_link_props_inst (.mclk(mclk), .rst_n(rst_n),
    .sample_clock_pos(link.sample_clock_pos), .word_drv(link.word_drv),
    .flag_drv(link.flag_drv), .strobe_p_drv(link.strobe_p_drv),
    .strobe_n_drv(link.strobe_n_drv), .out_oe_n(link.out_oe_n),
    .output_drive_disable(link.output_drive_disable), .power_down_pin(link.power_down_pin));

  initial mclk = 1'b0;
  always #(adc_link_pkg::MCLK_PERIOD_NS / 2) mclk = ~mclk;
  // link clock starts after reset, offset so its edges never meet mclk
  initial begin
    link.sample_clock_pos = 1'b0;
    #937 link.sample_clock_pos = 1'b1;
    forever #(adc_link_pkg::LINK_PERIOD_NS / 2) link.sample_clock_pos = ~link.sample_clock_pos;
  end
  assign link.sample_clock_neg = ~link.sample_clock_pos;

  task automatic stop_test();
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic timeout();
    mismatches++;
    stop_test();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // one avalon access; waitrequest and read data are taken at the same rising edge
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    int i;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= ~wr;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) timeout();
    rdata = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wait_level(input logic lvl);
    int i;
    for (i = 0; i < 40 && link.sample_clock_pos !== lvl; i++) @(posedge mclk);
    if (i == 40) timeout();
  endtask

  task automatic next_rise();
    wait_level(1'b0);
    wait_level(1'b1);
  endtask

  function automatic logic [16:0] exp_word(input logic signed [17:0] v, input logic [1:0] mode,
                                           input logic scr, input logic g);
    logic signed [19:0] x;
    logic [15:0]        w;
    x = 20'(v) + (g ? 20'(v >>> 1) : 20'sh00000);
    w = (x > adc_link_pkg::FS_MAX) ? adc_link_pkg::CLAMP_HI :
        (x < adc_link_pkg::FS_MIN) ? adc_link_pkg::CLAMP_LO : x[15:0];
    if (!mode[1]) w[15] = ~w[15];
    if (scr) w[15:1] = w[15:1] ^ {15{w[0]}};
    return {(x > adc_link_pkg::FS_MAX) || (x < adc_link_pkg::FS_MIN), w};
  endfunction

  // one marked sample between zero samples, seen on the wire and in the capture register
  task automatic run_case(input logic [1:0] mode, input logic scr, input logic g, input logic n,
                          input logic [1:0] src, input logic ds, input logic signed [17:0] v);
    output_format_strap <= mode;
    output_scramble_select <= scr;
    front_gain_select <= g;
    noise_inject_enable <= n;
    av(1'b1, adc_link_pkg::REG_CTRL, {28'h0, src, ds, 1'b1}, 4'hf);
    repeat (2) next_rise();
    @(negedge mclk);
    check(dither_active, n);
    check(stabilizer_active, mode[0] ^ mode[1]);
    check(twos_complement_active, mode[1]);
    check(gain_high_active, g);
    next_rise();
    repeat (5) @(posedge mclk);
    analog_level <= v;
    next_rise();
    repeat (5) @(posedge mclk);
    analog_level <= 18'sh00000;
    repeat (6) next_rise();
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check({link.range_exceed_flag, link.sample_word_bits}, exp_word(0, mode, scr, g));
    next_rise();
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check({link.range_exceed_flag, link.sample_word_bits}, exp_word(v, mode, scr, g));
    next_rise();
    repeat (3) @(posedge mclk);
    av(1'b0, adc_link_pkg::REG_DATA, 32'h0, 4'hf);
    check(rdata, {15'h0, exp_word(v, mode, scr ^ ds, g)});
    check({sample_flag_out, sample_word_out}, exp_word(v, mode, scr ^ ds, g));
  endtask

  initial begin
    int a;
    rst_n <= 1'b0;
    address <= 4'h0;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= 32'h0;
    byteenable <= 4'hf;
    analog_level <= 18'sh00000;
    output_format_strap <= 2'h0;
    noise_inject_enable <= 1'b0;
    output_scramble_select <= 1'b0;
    front_gain_select <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    // every address, unmapped ones included, reads zero after reset
    for (a = 0; a < 16; a++) begin
      av(1'b0, 4'(a), 32'h0, 4'hf);
      check(rdata, 32'h0);
    end
    run_case(2'h0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 18'sh01234);
    run_case(2'h1, 1'b1, 1'b0, 1'b1, 2'h1, 1'b1, 18'sh3fffb);
    run_case(2'h2, 1'b1, 1'b1, 1'b0, 2'h2, 1'b0, 18'sh06000);
    run_case(2'h3, 1'b0, 1'b1, 1'b1, 2'h3, 1'b0, 18'sh3a000);
    run_case(2'h2, 1'b0, 1'b0, 1'b1, 2'h0, 1'b1, 18'sh1ffff);
    av(1'b0, adc_link_pkg::REG_STATUS, 32'h0, 4'hf);
    check(rdata, 32'h7);
    check(irq, 1'b0);
    // a write without the low byte lane must not land
    av(1'b1, adc_link_pkg::REG_MASK, 32'h7, 4'he);
    av(1'b0, adc_link_pkg::REG_MASK, 32'h0, 4'hf);
    check(rdata, 32'h0);
    av(1'b1, adc_link_pkg::REG_MASK, 32'h1, 4'hf);
    @(negedge mclk);
    check(irq, 1'b1);
    av(1'b1, adc_link_pkg::REG_CTRL, 32'h0, 4'hf);
    av(1'b1, adc_link_pkg::REG_STATUS, 32'h7, 4'hf);
    av(1'b0, adc_link_pkg::REG_STATUS, 32'h0, 4'hf);
    check(rdata, 32'h0);
    @(negedge mclk);
    check(irq, 1'b0);
    av(1'b1, adc_link_pkg::REG_CTRL, 32'h1, 4'hf);
    for (a = 0; a < 40 && sample_strobe !== 1'b1; a++) @(posedge mclk);
    if (a == 40) timeout();
    // the capture strobe is a single-cycle pulse
    @(posedge mclk);
    check(sample_strobe, 1'b0);
    @(negedge mclk);
    check(irq, 1'b1);
    av(1'b1, adc_link_pkg::REG_MASK, 32'h0, 4'hf);
    @(negedge mclk);
    check(irq, 1'b0);
    av(1'b1, adc_link_pkg::REG_CTRL, 32'h11, 4'hf);
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check(link.out_oe_n, 1'b1);
    check(converting, 1'b1);
    av(1'b1, adc_link_pkg::REG_CTRL, 32'h21, 4'hf);
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check(converting, 1'b0);
    check({link.range_exceed_flag, link.sample_word_bits}, 32'h0);
    av(1'b1, adc_link_pkg::REG_CTRL, 32'h1, 4'hf);
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check(link.out_oe_n, 1'b0);
    check(converting, 1'b1);
    stop_test();
  end
endmodule
